// File: rtl/djsc_top.v
// command interpreter for bus voltage, velocity, position error and jog settings
// assumes decoded commands arrive as one-cycle strobes from the text parser
`timescale 1ns/100ps
`default_nettype none
`include "djsc_defines.vh"
// What this block does
// R1: voltage readout returns bus voltage count in tenths of a volt.
// R2: bus voltage at or above maximum limit latches a fault.
// R3: alarm flag set while bus voltage is below minimum limit.
// R4: voltage reply digits are hex or decimal per number format setting.
// R5: velocity selector 0 gives actual rpm, 1 gives target rpm.
// R6: position error readout returns commanded minus encoder position in counts.
// R7: writing jog acceleration also overwrites stored jog deceleration.
// R8: host writes acceleration first, then deceleration, for differing values.
// R9: stored jog acceleration is not changed while jogging.
// R10: jog acceleration accepted only in range 0.167 to 5461.167 steps; code accepts 1 to 0x7fdb, so at most 5455.167.
// R11: second speed used only in command modes 13, 14, 17, 18.
// R12: in those modes the speed select input picks primary or second speed.
// R13: second speed limited to 133.3333 rps, or 80 on integrated variants.
// R14: jog disable clears jog input enable for later wait instructions.
// R15: jog enable makes two inputs jog cw and ccw during wait instruction.
// R16: jog enable ignored while modes 7, 11, 12-18 own the shared inputs.
// R17: later of jog enable and limit definition 1 or 2 owns shared inputs.
// R18: host issues jog enable with command mode 21 or 22 to jog.
// R19: once awaited input condition met, jogging stops until next wait.
// R20: input low means current flows, treated as closed.
// R21: readout reply is two-letter name, equals sign and value.
module djsc_top (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        cmd_valid,
    input  wire [3:0]  cmd_op,
    input  wire [15:0] cmd_arg,
    input  wire        fmt_hex,
    input  wire        integrated_motor,
    input  wire [15:0] bus_voltage,
    input  wire [15:0] volt_max_limit,
    input  wire [15:0] volt_min_limit,
    input  wire [15:0] actual_velocity,
    input  wire [15:0] target_velocity,
    input  wire [31:0] commanded_pos,
    input  wire [31:0] encoder_pos,
    input  wire [15:0] primary_speed,
    input  wire [7:0]  reg_addr,
    input  wire        reg_rd,
    input  wire        jog_cw_input,
    input  wire        jog_ccw_input,
    input  wire        speed_select_input,
    input  wire        awaited_input,
    input  wire        awaited_level,
    input  wire        step_input,
    output reg  [15:0] reg_rdata_r,
    output reg         reg_rvalid_r,
    output reg         reply_valid_r,
    output reg  [15:0] reply_name_r,
    output reg  [7:0]  reply_eq_r,
    output reg  [39:0] reply_value_r,
    output reg         volt_fault_r,
    output reg         volt_alarm_r,
    output reg  [15:0] jog_accel_r,
    output reg  [15:0] jog_decel_r,
    output reg  [15:0] second_speed_r,
    output reg  [15:0] speed_out_r,
    output reg         jog_enable_r,
    output reg         limits_own_r,
    output reg         jog_active_r,
    output reg         jog_cw_r,
    output reg         jog_ccw_r,
    output reg         wait_active_r,
    output reg         wait_done_r,
    output reg         cmd_reject_r
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_CONV  = 2'h1;
    localparam ST_REPLY = 2'h2;

    function mode_owns_inputs;
        input [7:0] m;
        begin
            mode_owns_inputs = (m == 8'h07) || (m == 8'h0b) || (m >= 8'h0c && m <= 8'h12);
        end
    endfunction
    function osc_mode;
        input [7:0] m;
        begin
            osc_mode = (m == 8'h0d) || (m == 8'h0e) || (m == 8'h11) || (m == 8'h12);
        end
    endfunction

    wire [4:0]  pin_sync;
    wire [39:0] fmt_digits;
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [7:0]  cmd_mode_r;
    reg  [15:0] fmt_val_r;
    reg         fmt_hex_r;
    reg  [15:0] pend_name_r;
    wire [31:0] pos_diff;
    wire        cw_closed;
    wire        ccw_closed;
    wire        sel_closed;
    wire        await_closed;
    wire        wait_met;
    wire        is_cmd;
    wire [15:0] speed_max;

    djsc_sync u_sync (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .pin_in     ({step_input, awaited_input, speed_select_input, jog_ccw_input, jog_cw_input}),
        .pin_sync_r (pin_sync)
    );

    djsc_hexfmt u_fmt (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .value    (fmt_val_r),
        .hex_sel  (fmt_hex_r),
        .digits_r (fmt_digits)
    );

    // pins are active low: current flowing reads as 0, meaning closed
    assign cw_closed    = ~pin_sync[0]; // R20
    assign ccw_closed   = ~pin_sync[1]; // R20
    assign sel_closed   = ~pin_sync[2]; // R20
    assign await_closed = ~pin_sync[3]; // R20
    // awaited_level high waits for open, low waits for closed
    assign wait_met     = awaited_level ? ~await_closed : await_closed;
    assign pos_diff     = commanded_pos - encoder_pos; // R6
    // strobes while busy are dropped
    assign is_cmd       = cmd_valid && (state_r == ST_IDLE);
    assign speed_max    = integrated_motor ? `DJSC_SPEED_MAX_INT : `DJSC_SPEED_MAX_STD; // R13

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (is_cmd && (cmd_op == `DJSC_OP_VOLT_RD || cmd_op == `DJSC_OP_VEL_RD ||
                               cmd_op == `DJSC_OP_POSERR_RD)) state_nxt = ST_CONV;
            end
            ST_CONV: state_nxt = ST_REPLY;
            ST_REPLY: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // readout path; write-only and setting commands never produce a reply
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r       <= ST_IDLE;
            fmt_val_r     <= 16'h0000;
            fmt_hex_r     <= 1'b0;
            pend_name_r   <= 16'h0000;
            reply_valid_r <= 1'b0;
            reply_name_r  <= 16'h0000;
            reply_eq_r    <= 8'h00;
            reply_value_r <= 40'h00_0000_0000;
        end else begin
            state_r       <= state_nxt;
            reply_valid_r <= 1'b0;
            if (is_cmd) begin
                case (cmd_op)
                    `DJSC_OP_VOLT_RD: begin
                        fmt_val_r   <= bus_voltage; // R1
                        fmt_hex_r   <= fmt_hex; // R4
                        pend_name_r <= `DJSC_NAME_VOLT;
                    end
                    `DJSC_OP_VEL_RD: begin
                        fmt_val_r   <= cmd_arg[0] ? target_velocity : actual_velocity; // R5
                        fmt_hex_r   <= 1'b0;
                        pend_name_r <= `DJSC_NAME_VEL;
                    end
                    `DJSC_OP_POSERR_RD: begin
                        fmt_val_r   <= pos_diff[15:0]; // R6
                        fmt_hex_r   <= 1'b0;
                        pend_name_r <= `DJSC_NAME_POSERR;
                    end
                    default: begin
                        fmt_val_r <= fmt_val_r;
                    end
                endcase
            end
            if (state_r == ST_REPLY) begin
                reply_valid_r <= 1'b1; // R21
                reply_name_r  <= pend_name_r; // R21
                reply_eq_r    <= 8'h3d; // R21
                reply_value_r <= fmt_digits; // R21
            end
        end
    end

    // register readout port
    // reads answer on the next edge
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_r  <= 16'h0000;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `DJSC_REG_BUS_VOLT: reg_rdata_r <= bus_voltage; // R1
                    `DJSC_REG_ACT_VEL:  reg_rdata_r <= actual_velocity; // R5
                    `DJSC_REG_TGT_VEL:  reg_rdata_r <= target_velocity; // R5
                    `DJSC_REG_POS_ERR:  reg_rdata_r <= pos_diff[15:0]; // R6
                    default:            reg_rdata_r <= 16'h0000;
                endcase
            end
        end
    end

    // bus voltage supervision; fault latches until reset
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            volt_fault_r <= 1'b0;
            volt_alarm_r <= 1'b0;
        end else begin
            if (bus_voltage >= volt_max_limit) volt_fault_r <= 1'b1; // R2
            volt_alarm_r <= (bus_voltage < volt_min_limit); // R3
        end
    end

    // buffered settings and input ownership
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            jog_accel_r    <= `DJSC_ACCEL_RESET;
            jog_decel_r    <= `DJSC_ACCEL_RESET;
            second_speed_r <= `DJSC_SPEED_RESET;
            cmd_mode_r     <= `DJSC_MODE_RESET;
            jog_enable_r   <= 1'b0;
            limits_own_r   <= 1'b0;
            cmd_reject_r   <= 1'b0;
        end else begin
            cmd_reject_r <= 1'b0;
            if (is_cmd) begin
                case (cmd_op)
                    `DJSC_OP_JOG_ACCEL: begin
                        // out-of-range or mid-jog writes are dropped, not clamped
                        if (!jog_active_r && cmd_arg >= `DJSC_ACCEL_MIN && cmd_arg <= `DJSC_ACCEL_MAX) begin // R9 R10
                            jog_accel_r <= cmd_arg; // R7
                            jog_decel_r <= cmd_arg; // R7 R8
                        end else begin
                            cmd_reject_r <= 1'b1;
                        end
                    end

                    `DJSC_OP_JOG_DECEL: begin
                        if (!jog_active_r && cmd_arg >= `DJSC_ACCEL_MIN && cmd_arg <= `DJSC_ACCEL_MAX) begin
                            jog_decel_r <= cmd_arg; // R8
                        end else begin
                            cmd_reject_r <= 1'b1;
                        end
                    end

                    `DJSC_OP_SECOND_SPEED: begin
                        if (cmd_arg >= `DJSC_SPEED_MIN && cmd_arg <= speed_max) begin // R13
                            second_speed_r <= cmd_arg;
                        end else begin
                            cmd_reject_r <= 1'b1;
                        end
                    end

                    `DJSC_OP_JOG_DISABLE: jog_enable_r <= 1'b0; // R14
                    `DJSC_OP_JOG_ENABLE: begin
                        if (mode_owns_inputs(cmd_mode_r)) begin // R16
                            cmd_reject_r <= 1'b1;
                        end else begin
                            jog_enable_r <= 1'b1; // R15 R17 R18
                            limits_own_r <= 1'b0; // R17
                        end
                    end

                    `DJSC_OP_LIMIT_DEF: begin
                        if (cmd_arg[7:0] == 8'h01 || cmd_arg[7:0] == 8'h02) begin
                            if (!mode_owns_inputs(cmd_mode_r)) begin // R16
                                limits_own_r <= 1'b1; // R17
                                jog_enable_r <= 1'b0; // R17
                            end
                        end else begin
                            limits_own_r <= 1'b0;
                        end
                    end

                    `DJSC_OP_CMD_MODE: begin
                        cmd_mode_r <= cmd_arg[7:0];
                        // owning modes take the shared inputs away at once
                        if (mode_owns_inputs(cmd_arg[7:0])) begin
                            jog_enable_r <= 1'b0; // R16
                            limits_own_r <= 1'b0; // R16
                        end
                    end
                    default: cmd_reject_r <= 1'b0;
                endcase
            end
        end
    end

    // oscillator speed selection
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            speed_out_r <= 16'h0000;
        end else if (osc_mode(cmd_mode_r) && sel_closed) begin // R11 R12
            speed_out_r <= second_speed_r;
        end else begin
            speed_out_r <= primary_speed; // R11
        end
    end

    // wait instruction and jog drive
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wait_active_r <= 1'b0;
            wait_done_r   <= 1'b0;
            jog_active_r  <= 1'b0;
            jog_cw_r      <= 1'b0;
            jog_ccw_r     <= 1'b0;
        end else begin
            wait_done_r <= 1'b0;
            // a new wait wins over a met condition
            if (is_cmd && cmd_op == `DJSC_OP_WAIT_INPUT) begin
                wait_active_r <= 1'b1;
            end else if (wait_active_r && wait_met) begin
                wait_active_r <= 1'b0; // R19
                wait_done_r   <= 1'b1;
            end

            // jogging only while waiting, enabled, and condition not yet met
            if (wait_active_r && !wait_met && jog_enable_r && !mode_owns_inputs(cmd_mode_r)) begin // R15 R16
                jog_cw_r     <= cw_closed && !ccw_closed; // R15
                jog_ccw_r    <= ccw_closed && !cw_closed; // R15
                jog_active_r <= cw_closed ^ ccw_closed;
            end else begin
                jog_cw_r     <= 1'b0; // R14 R19
                jog_ccw_r    <= 1'b0; // R19
                jog_active_r <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: shared/djsc_defines.vh
// constants for the drive jog and status command block
// assumes inclusion by bare name from rtl files
`ifndef DJSC_DEFINES_VH
`define DJSC_DEFINES_VH
`define DJSC_REG_BUS_VOLT     8'h45
`define DJSC_REG_ACT_VEL      8'h46
`define DJSC_REG_TGT_VEL      8'h47
`define DJSC_REG_POS_ERR      8'h48
`define DJSC_OP_VOLT_RD       4'h1
`define DJSC_OP_VEL_RD        4'h2
`define DJSC_OP_POSERR_RD     4'h3
`define DJSC_OP_JOG_ACCEL     4'h4
`define DJSC_OP_JOG_DECEL     4'h5
`define DJSC_OP_SECOND_SPEED  4'h6
`define DJSC_OP_JOG_DISABLE   4'h7
`define DJSC_OP_JOG_ENABLE    4'h8
`define DJSC_OP_LIMIT_DEF     4'h9
`define DJSC_OP_CMD_MODE      4'ha
`define DJSC_OP_WAIT_INPUT    4'hb
`define DJSC_ACCEL_MIN        16'h0001
`define DJSC_ACCEL_MAX        16'h7fdb
`define DJSC_SPEED_MIN        16'h0001
`define DJSC_SPEED_MAX_STD    16'h7a12
`define DJSC_SPEED_MAX_INT    16'h493e
`define DJSC_ACCEL_RESET      16'h0258
`define DJSC_SPEED_RESET      16'h0000
`define DJSC_MODE_RESET       8'h15
`define DJSC_NAME_VOLT        16'h4955
`define DJSC_NAME_VEL         16'h4956
`define DJSC_NAME_POSERR      16'h4958
`endif

// File: rtl/djsc_hexfmt.v
// converts a 16-bit value into ascii hex or decimal digits
// assumes a registered, single-cycle conversion is enough
`timescale 1ns/100ps
`default_nettype none
module djsc_hexfmt (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire [15:0] value,
    input  wire        hex_sel,
    output reg  [39:0] digits_r
);
    function [7:0] asc;
        input [3:0] d;
        begin
            asc = (d < 4'ha) ? {4'h3, d} : (8'h37 + {4'h0, d});
        end
    endfunction
    reg [19:0] bcd;
    integer    i;
    always @* begin
        bcd = 20'h0_0000;
        // double dabble; wide enough for 65535
        for (i = 15; i >= 0; i = i - 1) begin
            if (bcd[3:0] > 4'h4) bcd[3:0] = bcd[3:0] + 4'h3;
            if (bcd[7:4] > 4'h4) bcd[7:4] = bcd[7:4] + 4'h3;
            if (bcd[11:8] > 4'h4) bcd[11:8] = bcd[11:8] + 4'h3;
            if (bcd[15:12] > 4'h4) bcd[15:12] = bcd[15:12] + 4'h3;
            bcd = {bcd[18:0], value[i]};
        end
    end
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            digits_r <= 40'h00_0000_0000;
        end else if (hex_sel) begin
            digits_r <= {8'h20, asc(value[15:12]), asc(value[11:8]), asc(value[7:4]), asc(value[3:0])}; // R4
        end else begin
            digits_r <= {asc(bcd[19:16]), asc(bcd[15:12]), asc(bcd[11:8]), asc(bcd[7:4]), asc(bcd[3:0])}; // R4
        end
    end
endmodule
`default_nettype wire

// File: rtl/djsc_sync.v
// two-flop synchroniser for pin inputs
// assumes async pins; first flop read only by the second
`timescale 1ns/100ps
`default_nettype none
module djsc_sync (
    input  wire       mclk,
    input  wire       rst_b,
    input  wire [4:0] pin_in,
    output reg  [4:0] pin_sync_r
);
    reg [4:0] meta_r;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r     <= 5'h1f;
            pin_sync_r <= 5'h1f;
        end else begin
            meta_r     <= pin_in;
            pin_sync_r <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: verif/djsc_checker.sv
// concurrent checks on the ports of the jog and status command block
// assumes one clock domain, mclk, with asynchronous active-low rst_b
`timescale 1ns/100ps
`default_nettype none
module djsc_checker (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        cmd_valid,
    input wire logic [3:0]  cmd_op,
    input wire logic [15:0] cmd_arg,
    input wire logic [15:0] bus_voltage,
    input wire logic [15:0] volt_max_limit,
    input wire logic [15:0] volt_min_limit,
    input wire logic        reply_valid_r,
    input wire logic [15:0] reply_name_r,
    input wire logic [7:0]  reply_eq_r,
    input wire logic        volt_fault_r,
    input wire logic        volt_alarm_r,
    input wire logic [15:0] jog_accel_r,
    input wire logic [15:0] jog_decel_r,
    input wire logic        jog_active_r,
    input wire logic        wait_active_r,
    input wire logic        wait_done_r,
    input wire logic        cmd_reject_r
);
    default clocking dclk @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // bench never strobes a readout while busy
    property p_volt_reply;
        cmd_valid && cmd_op == 4'h1 |-> ##[2:5] reply_valid_r && reply_name_r == 16'h4955 && reply_eq_r == 8'h3d;
    endproperty
    property p_vel_reply;
        cmd_valid && cmd_op == 4'h2 |-> ##[2:5] reply_valid_r && reply_name_r == 16'h4956;
    endproperty
    property p_fault_set;
        bus_voltage >= volt_max_limit |=> volt_fault_r;
    endproperty
    property p_fault_sticky;
        volt_fault_r |=> volt_fault_r;
    endproperty
    property p_alarm;
        1'b1 |=> volt_alarm_r == ($past(bus_voltage) < $past(volt_min_limit));
    endproperty
    property p_accel_both;
        cmd_valid && cmd_op == 4'h4 && cmd_arg != 16'h0000 && cmd_arg <= 16'h7fdb && !jog_active_r
            |=> jog_accel_r == $past(cmd_arg) && jog_decel_r == $past(cmd_arg);
    endproperty
    property p_accel_range;
        cmd_valid && cmd_op == 4'h4 && (cmd_arg == 16'h0000 || cmd_arg > 16'h7fdb) |-> ##[1:2] cmd_reject_r;
    endproperty
    property p_accel_jog;
        jog_active_r |=> $stable(jog_accel_r);
    endproperty
    property p_wait_done;
        wait_done_r |-> !wait_active_r;
    endproperty
    a_volt_reply: assert property (p_volt_reply) else $error("voltage reply missing or misnamed");
    a_vel_reply: assert property (p_vel_reply) else $error("velocity reply missing or misnamed");
    a_fault_set: assert property (p_fault_set) else $error("fault not set at max voltage");
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault cleared by itself");
    a_alarm: assert property (p_alarm) else $error("alarm does not track min voltage");
    a_accel_both: assert property (p_accel_both) else $error("accel write did not set both rates");
    a_accel_range: assert property (p_accel_range) else $error("out of range accel not refused");
    a_accel_jog: assert property (p_accel_jog) else $error("accel changed while jogging");
    a_wait_done: assert property (p_wait_done) else $error("wait still active when done");
    c_reply: cover property (reply_valid_r);
    c_fault: cover property (volt_fault_r);
    c_wait_done: cover property (wait_done_r);
endmodule
bind djsc_top djsc_checker u_chk (.*);
`default_nettype wire

// File: verif/djsc_host_model.sv
// host controller model: issues decoded commands and collects readout replies
// assumes the block takes one-cycle strobes on the rising edge of mclk
`timescale 1ns/100ps
`default_nettype none
module djsc_host_model (
    input  wire logic        mclk,
    input  wire logic        reply_valid_r,
    input  wire logic [15:0] reply_name_r,
    input  wire logic [39:0] reply_value_r,
    output var  logic        cmd_valid,
    output var  logic [3:0]  cmd_op,
    output var  logic [15:0] cmd_arg
);
    logic [15:0] last_name;
    logic [39:0] last_value;
    logic        got_reply;
    initial begin
        cmd_valid = 1'b0;
        cmd_op = 4'h0;
        cmd_arg = 16'h0000;
    end
    // idle fields are scrambled so a stale argument never looks valid
    task send(input logic [3:0] op, input logic [15:0] arg);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_arg = arg;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_op = ~op;
        cmd_arg = ~arg;
    endtask
    task readout(input logic [3:0] op, input logic [15:0] arg);
        got_reply = 1'b0;
        send(op, arg);
        repeat (8) begin
            @(negedge mclk);
            if (!got_reply && reply_valid_r === 1'b1) begin
                got_reply = 1'b1;
                last_name = reply_name_r;
                last_value = reply_value_r;
            end
        end
    endtask
endmodule
`default_nettype wire

// File: verif/tb_drive_jog_status_commands.sv
// self-checking bench for the jog and status command block
// assumes the host model in djsc_host_model.sv and inputs driven at the falling edge
`timescale 1ns/100ps
`default_nettype none
module tb_drive_jog_status_commands;
    logic        mclk, rst_b, cmd_valid, fmt_hex, integrated_motor, reg_rd, awaited_level, rej_seen;
    logic        jog_cw_input, jog_ccw_input, speed_select_input, awaited_input, step_input;
    logic [3:0]  cmd_op;
    logic [7:0]  reg_addr, reply_eq_r;
    logic [15:0] cmd_arg, bus_voltage, volt_max_limit, volt_min_limit, actual_velocity, target_velocity;
    logic [15:0] primary_speed, reg_rdata_r, reply_name_r, jog_accel_r, jog_decel_r, second_speed_r, speed_out_r;
    logic [31:0] commanded_pos, encoder_pos;
    logic [39:0] reply_value_r;
    logic        reg_rvalid_r, reply_valid_r, volt_fault_r, volt_alarm_r, jog_enable_r, limits_own_r;
    logic        jog_active_r, jog_cw_r, jog_ccw_r, wait_active_r, wait_done_r, cmd_reject_r;
    logic [7:0]  modes[5] = '{8'h0d, 8'h0e, 8'h11, 8'h12, 8'h15};
    logic [7:0]  owners[9] = '{8'h07, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12};
    int          fails = 0;
    int          samples_checked = 0;
    djsc_top u_dut (.*);
    djsc_host_model u_host (.*);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) if (cmd_reject_r === 1'b1) rej_seen <= 1'b1;
    task complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // refusal may show one cycle late, so it is latched over two cycles
    task set(input logic [3:0] op, input logic [15:0] arg);
        rej_seen = 1'b0;
        u_host.send(op, arg);
        cyc(2);
    endtask
    task rd(input logic [7:0] a, input logic [15:0] exp);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        chk("reg_rvalid", 40'h1, reg_rvalid_r);
        chk("reg_rdata", exp, reg_rdata_r);
    endtask
    // decimal padding is free, so only the low digits are compared
    task ro(input logic [3:0] op, input logic [15:0] arg, nm, input logic [39:0] v, m);
        u_host.readout(op, arg);
        chk("reply_name", nm, u_host.last_name);
        chk("reply_value", v, u_host.last_value & m);
    endtask
    initial begin
        #1_000_000;
        fails++;
        complete_run;
    end
    initial begin
        {rst_b, integrated_motor, reg_rd, rej_seen, awaited_level, reg_addr} = 13'h0000;
        fmt_hex = 1'b1;
        {bus_voltage, volt_max_limit, volt_min_limit, primary_speed} = 64'h01e2_1000_0100_0100;
        {actual_velocity, target_velocity, commanded_pos, encoder_pos} = 96'h03e8_00fa_0000_006e_0000_0064;
        {jog_cw_input, jog_ccw_input, speed_select_input, awaited_input, step_input} = 5'h1f;
        cyc(5);
        rst_b = 1'b1;
        cyc(2);
        chk("accel_reset", 16'h0258, jog_accel_r);
        chk("decel_reset", 16'h0258, jog_decel_r);
        ro(4'h1, 16'h0000, 16'h4955, 40'h20_3031_4532, 40'hff_ffff_ffff);
        fmt_hex = 1'b0;
        bus_voltage = 16'h067e;
        ro(4'h1, 16'h0000, 16'h4955, 40'h00_3136_3632, 40'h00_ffff_ffff);
        ro(4'h2, 16'h0000, 16'h4956, 40'h00_3130_3030, 40'h00_ffff_ffff);
        ro(4'h2, 16'h0001, 16'h4956, 40'h00_0032_3530, 40'h00_00ff_ffff);
        ro(4'h3, 16'h0000, 16'h4958, 40'h00_0000_3130, 40'h00_0000_ffff);
        rd(8'h45, 16'h067e);
        rd(8'h46, 16'h03e8);
        rd(8'h47, 16'h00fa);
        rd(8'h48, 16'h000a);
        rd(8'h49, 16'h0000);
        $display("test readouts done");
        set(4'h4, 16'h0064);
        chk("decel", 16'h0064, jog_decel_r);
        set(4'h5, 16'h0032);
        chk("decel", 16'h0032, jog_decel_r);
        chk("accel", 16'h0064, jog_accel_r);
        set(4'h4, 16'h0000);
        chk("reject", 40'h1, rej_seen);
        set(4'h4, 16'h7fdb);
        chk("accel", 16'h7fdb, jog_accel_r);
        set(4'h4, 16'h7fdc);
        chk("reject", 40'h1, rej_seen);
        chk("accel", 16'h7fdb, jog_accel_r);
        set(4'h6, 16'h7a12);
        chk("speed", 16'h7a12, second_speed_r);
        integrated_motor = 1'b1;
        set(4'h6, 16'h7a12);
        chk("reject", 40'h1, rej_seen);
        set(4'h6, 16'h493e);
        chk("speed", 16'h493e, second_speed_r);
        integrated_motor = 1'b0;
        $display("test settings done");
        for (int i = 0; i < 5; i++) begin
            set(4'ha, {8'h00, modes[i]});
            speed_select_input = 1'b0;
            cyc(5);
            chk("speed_out", (i < 4) ? 16'h493e : 16'h0100, speed_out_r);
            speed_select_input = 1'b1;
            cyc(5);
            chk("speed_out", 16'h0100, speed_out_r);
        end
        for (int i = 0; i < 9; i++) begin
            set(4'ha, {8'h00, owners[i]});
            set(4'h8, 16'h0000);
            chk("jog_enable", 40'h0, jog_enable_r);
        end
        set(4'ha, 16'h0015);
        set(4'h8, 16'h0000);
        chk("jog_enable", 40'h1, jog_enable_r);
        for (int d = 1; d < 3; d++) begin
            set(4'h9, d[15:0]);
            chk("limits_own", 40'h1, limits_own_r);
            chk("jog_enable", 40'h0, jog_enable_r);
        end
        set(4'h8, 16'h0000);
        chk("limits_own", 40'h0, limits_own_r);
        set(4'hb, 16'h0000);
        chk("wait_active", 40'h1, wait_active_r);
        jog_cw_input = 1'b0;
        cyc(5);
        chk("jog_cw", 40'h1, jog_cw_r);
        chk("jog_active", 40'h1, jog_active_r);
        set(4'h4, 16'h0010);
        chk("accel", 16'h7fdb, jog_accel_r);
        jog_cw_input = 1'b1;
        jog_ccw_input = 1'b0;
        cyc(5);
        chk("jog_ccw", 40'h1, jog_ccw_r);
        awaited_input = 1'b0;
        cyc(5);
        chk("wait_active", 40'h0, wait_active_r);
        chk("jog_ccw", 40'h0, jog_ccw_r);
        awaited_input = 1'b1;
        set(4'h7, 16'h0000);
        chk("jog_enable", 40'h0, jog_enable_r);
        set(4'hb, 16'h0000);
        cyc(5);
        chk("jog_ccw", 40'h0, jog_ccw_r);
        jog_ccw_input = 1'b1;
        awaited_input = 1'b0;
        cyc(5);
        $display("test jog done");
        bus_voltage = 16'h0080;
        cyc(3);
        chk("alarm", 40'h1, volt_alarm_r);
        bus_voltage = 16'h1000;
        cyc(3);
        chk("fault", 40'h1, volt_fault_r);
        bus_voltage = 16'h0200;
        cyc(3);
        chk("fault", 40'h1, volt_fault_r);
        chk("alarm", 40'h0, volt_alarm_r);
        $display("test supervision done");
        complete_run;
    end
endmodule
`default_nettype wire
